//--- verilog/cms_cfg.svh
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CMS_OFF_CTRL0 8'h00
`define CMS_OFF_VAL0 8'h14
`define CMS_OFF_TSEL_A 8'h28
`define CMS_OFF_TSEL_B 8'h2c
`define CMS_OFF_DB0 8'h30
`define CMS_OFF_FLAGS 8'h3c
`define CMS_OFF_RELOC 8'h40
`define CMS_OFF_PINS 8'h44

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMS_CFG_MSB 7
`define CMS_CFG_LSB 6
`define CMS_DLOW_MSB 5
`define CMS_DLOW_LSB 4
`define CMS_MODE_MSB 3
`define CMS_MODE_LSB 0
`define CMS_TSEL_W 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CMS_CTRL_RST 8'h00
`define CMS_VAL_RST 16'h0000
`define CMS_TSEL_A_RST 8'h00
`define CMS_TSEL_B_RST 2'h0
`define CMS_DB_RST 7'h00
`define CMS_RELOC_RST 8'h00

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define CMS_PSC4_LAST 4'h3
`define CMS_PSC16_LAST 4'hf
`define CMS_DB_MAX 7'h7f
`define CMS_TSEL_RSVD 2'h3

`endif

//--- verilog/cms_pkg.sv
`default_nettype none

package cms_pkg;

    // Mode select field codes.
    typedef enum logic [3:0] {
        MD_OFF = 4'h0,
        MD_RSVD1 = 4'h1,
        MD_TOGGLE = 4'h2,
        MD_RSVD3 = 4'h3,
        MD_CAP_FALL = 4'h4,
        MD_CAP_RISE = 4'h5,
        MD_CAP_RISE4 = 4'h6,
        MD_CAP_RISE16 = 4'h7,
        MD_SET_HIGH = 4'h8,
        MD_SET_LOW = 4'h9,
        MD_SOFT_INT = 4'ha,
        MD_SPECIAL = 4'hb
    } cms_mode_t;

    // Broad function selected by the mode field.
    typedef enum logic [2:0] {
        FN_OFF = 3'b000,
        FN_CAPTURE = 3'b001,
        FN_COMPARE = 3'b010,
        FN_PWM = 3'b011,
        FN_RSVD = 3'b100
    } cms_func_t;

    // Output configuration field codes.
    typedef enum logic [1:0] {
        OC_SINGLE = 2'b00,
        OC_FULL_FWD = 2'b01,
        OC_HALF = 2'b10,
        OC_FULL_REV = 2'b11
    } cms_ocfg_t;

endpackage

`default_nettype wire

//--- verilog/cms_channel.sv
`include "cms_cfg.svh"
`default_nettype none

module cms_channel #(
    parameter bit ENH = 1'b1
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Configuration.
    input wire logic [3:0] mode,
    input wire logic [1:0] ocfg,
    input wire logic [9:0] duty,
    input wire logic [15:0] cmp_val,
    input wire logic [1:0] tsel,
    input wire logic [6:0] db_count,
    // Time bases and inputs.
    input wire logic [29:0] tmr_count,
    input wire logic [2:0] tmr_period,
    input wire logic [15:0] base_count,
    input wire logic cap_in,
    input wire logic adc_en,
    // Events and pins.
    output logic cap_evt_ff,
    output logic cmp_evt_ff,
    output logic tmr_rst_ff,
    output logic adc_go_ff,
    output logic [3:0] lvl_ff,
    output logic [3:0] oe_n_ff
);

    cms_pkg::cms_func_t func;
    logic [3:0] mode_q_ff;
    logic cap_q_ff;
    logic [3:0] psc_ff;
    logic match_q_ff;
    logic cmp_pin_ff;
    logic [9:0] duty_lat_ff;
    logic raw_ff;
    logic raw_q_ff;
    logic [6:0] db_cnt_ff;
    logic chg;
    logic edge_ok;
    logic hit;
    logic tsel_ok;
    logic [9:0] cnt;
    logic pola;
    logic polb;
    logic db_ok;
    logic [3:0] nxt_lvl;
    logic [3:0] nxt_oe_n;

    // Decode the mode field into a broad function.
    always_comb begin
        unique case (mode[3:2])
            2'b00: begin
                if (mode[1:0] == 2'b00) begin
                    func = cms_pkg::FN_OFF;
                end else if (mode[1:0] == 2'b10) begin
                    func = cms_pkg::FN_COMPARE;
                end else begin
                    func = cms_pkg::FN_RSVD;
                end
            end
            2'b01: func = cms_pkg::FN_CAPTURE;
            2'b10: func = cms_pkg::FN_COMPARE;
            2'b11: func = cms_pkg::FN_PWM;
        endcase
    end

    assign chg = (mode != mode_q_ff);
    assign tsel_ok = (tsel != `CMS_TSEL_RSVD);
    assign cnt = tmr_count[10 * tsel +: 10];
    assign pola = ENH & mode[1];
    assign polb = ENH & mode[0];
    // The edge cycle itself is only clear with a zero count, so no stale count lets a pulse through.
    assign db_ok = (raw_ff != raw_q_ff) ? (db_count == 7'h00) : (db_cnt_ff >= db_count);
    assign edge_ok = (mode == cms_pkg::MD_CAP_FALL) ? (~cap_in & cap_q_ff) : (cap_in & ~cap_q_ff);
    assign hit = (base_count == cmp_val) & ~match_q_ff & (func == cms_pkg::FN_COMPARE) & ~chg;

    // Track the previous mode, input level and match.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q_ff <= 4'h0;
            cap_q_ff <= 1'b0;
            match_q_ff <= 1'b0;
        end else begin
            mode_q_ff <= mode;
            cap_q_ff <= cap_in;
            match_q_ff <= (base_count == cmp_val);
        end
    end

    // Capture edge selection and prescaler.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_ff <= 4'h0;
            cap_evt_ff <= 1'b0;
        end else if (func != cms_pkg::FN_CAPTURE || chg) begin
            psc_ff <= 4'h0;
            cap_evt_ff <= 1'b0;
        end else if (mode == cms_pkg::MD_CAP_RISE4 || mode == cms_pkg::MD_CAP_RISE16) begin
            cap_evt_ff <= 1'b0;
            if (edge_ok) begin
                if (psc_ff == ((mode == cms_pkg::MD_CAP_RISE4) ? `CMS_PSC4_LAST : `CMS_PSC16_LAST)) begin
                    psc_ff <= 4'h0;
                    cap_evt_ff <= 1'b1;
                end else begin
                    psc_ff <= psc_ff + 4'h1;
                end
            end
        end else begin
            cap_evt_ff <= edge_ok;
        end
    end

    // Compare pin level and compare events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_pin_ff <= 1'b0;
            cmp_evt_ff <= 1'b0;
            tmr_rst_ff <= 1'b0;
            adc_go_ff <= 1'b0;
        end else begin
            if (chg) begin
                cmp_pin_ff <= (mode == cms_pkg::MD_SET_LOW);
            end else if (hit && mode == cms_pkg::MD_SET_HIGH) begin
                cmp_pin_ff <= 1'b1;
            end else if (hit && mode == cms_pkg::MD_SET_LOW) begin
                cmp_pin_ff <= 1'b0;
            end else if (hit && mode == cms_pkg::MD_TOGGLE) begin
                cmp_pin_ff <= ~cmp_pin_ff;
            end
            cmp_evt_ff <= hit;
            tmr_rst_ff <= hit & (mode == cms_pkg::MD_SPECIAL);
            adc_go_ff <= hit & (mode == cms_pkg::MD_SPECIAL) & adc_en;
        end
    end

    // Raw pulse width modulation with duty latched at each period start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_lat_ff <= 10'h000;
            raw_ff <= 1'b0;
        end else if (func != cms_pkg::FN_PWM || !tsel_ok) begin
            duty_lat_ff <= 10'h000;
            raw_ff <= 1'b0;
        end else begin
            if (tmr_period[tsel]) begin
                duty_lat_ff <= duty;
            end
            raw_ff <= (cnt < duty_lat_ff);
        end
    end

    // Dead-band counter, one step per instruction cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_q_ff <= 1'b0;
            db_cnt_ff <= 7'h00;
        end else begin
            raw_q_ff <= raw_ff;
            if (raw_ff != raw_q_ff) begin
                db_cnt_ff <= 7'h01;
            end else if (db_cnt_ff != `CMS_DB_MAX) begin
                db_cnt_ff <= db_cnt_ff + 7'h01;
            end
        end
    end

    // Pin steering per function and output configuration; bits are d, c, b, a.
    always_comb begin
        nxt_lvl = 4'h0;
        nxt_oe_n = 4'hf;
        if (func == cms_pkg::FN_PWM && tsel_ok) begin
            if (!ENH) begin
                nxt_lvl[0] = raw_ff;
                nxt_oe_n[0] = 1'b0;
            end else begin
                unique case (ocfg)
                    cms_pkg::OC_SINGLE: begin
                        nxt_lvl[0] = raw_ff ^ pola;
                        nxt_oe_n = 4'he;
                    end
                    cms_pkg::OC_FULL_FWD: begin
                        nxt_lvl = {raw_ff ^ polb, pola, polb, ~pola};
                        nxt_oe_n = 4'h0;
                    end
                    cms_pkg::OC_HALF: begin
                        nxt_lvl[0] = (raw_ff & db_ok) ^ pola;
                        nxt_lvl[1] = (~raw_ff & db_ok) ^ polb;
                        nxt_oe_n = 4'hc;
                    end
                    cms_pkg::OC_FULL_REV: begin
                        nxt_lvl = {polb, ~pola, raw_ff ^ polb, pola};
                        nxt_oe_n = 4'h0;
                    end
                endcase
            end
        end else if (func == cms_pkg::FN_COMPARE && mode != cms_pkg::MD_SOFT_INT) begin
            nxt_lvl[0] = cmp_pin_ff;
            nxt_oe_n[0] = 1'b0;
        end
    end

    // Registered pin drive.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_ff <= 4'h0;
            oe_n_ff <= 4'hf;
        end else begin
            lvl_ff <= nxt_lvl;
            oe_n_ff <= nxt_oe_n;
        end
    end

endmodule

`default_nettype wire

//--- verilog/cms_top.sv
`include "cms_cfg.svh"
`default_nettype none

module cms_top (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Period timers and capture time base.
    input wire logic [29:0] tmr_count,
    input wire logic [2:0] tmr_period,
    input wire logic [15:0] base_count,
    input wire logic adc_enabled,
    // Capture pins, asynchronous.
    input wire logic [4:0] capture_pin,
    // Output pins, four per channel in order a, b, c, d.
    output logic [19:0] out_level,
    output logic [19:0] out_oe_n,
    // Events to the rest of the device.
    output logic [4:0] timer_reset,
    output logic adc_start,
    output logic [7:0] pin_relocation
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] ctrl_ff [5];
    logic [15:0] val_ff [5];
    logic [7:0] tsel_a_ff;
    logic [1:0] tsel_b_ff;
    logic [6:0] db_ff [3];
    logic [4:0] flag_ff;
    logic [7:0] reloc_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic adc_start_ff;
    logic [4:0] cap_s1_ff;
    logic [4:0] cap_s2_ff;

    // ----------------------------------------------------------------
    // Channel signals
    // ----------------------------------------------------------------
    logic [4:0] cap_evt;
    logic [4:0] cmp_evt;
    logic [4:0] tmr_rst;
    logic [4:0] adc_go;
    logic [19:0] lvl;
    logic [19:0] oe_n;
    logic [1:0] tsel [5];

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic wr_done;
    logic rd_take;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [4:0] ctrl_wr;
    logic [4:0] val_wr;
    logic [2:0] db_wr;
    logic tsel_a_wr;
    logic tsel_b_wr;
    logic flag_wr;
    logic reloc_wr;

    // The write lands at the completing edge; read data is latched one edge earlier.
    assign wr_done = psel & penable & pready_ff & pwrite;
    assign rd_take = psel & penable & ~pready_ff;

    // Per-register write strobes.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            ctrl_wr[i] = wr_done & (paddr == 8'(`CMS_OFF_CTRL0 + 4 * i));
            val_wr[i] = wr_done & (paddr == 8'(`CMS_OFF_VAL0 + 4 * i));
        end
        for (int i = 0; i < 3; i++) begin
            db_wr[i] = wr_done & (paddr == 8'(`CMS_OFF_DB0 + 4 * i));
        end
        tsel_a_wr = wr_done & (paddr == `CMS_OFF_TSEL_A);
        tsel_b_wr = wr_done & (paddr == `CMS_OFF_TSEL_B);
        flag_wr = wr_done & (paddr == `CMS_OFF_FLAGS);
        reloc_wr = wr_done & (paddr == `CMS_OFF_RELOC);
    end

    // Read multiplexer; unmapped addresses read zero with an error.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == `CMS_OFF_TSEL_A) begin
            rd_data[7:0] = tsel_a_ff;
        end else if (paddr == `CMS_OFF_TSEL_B) begin
            rd_data[1:0] = tsel_b_ff;
        end else if (paddr == `CMS_OFF_FLAGS) begin
            rd_data[4:0] = flag_ff;
        end else if (paddr == `CMS_OFF_RELOC) begin
            rd_data[7:0] = reloc_ff;
        end else if (paddr == `CMS_OFF_PINS) begin
            rd_data[19:0] = lvl;
        end else begin
            rd_hit = 1'b0;
            for (int i = 0; i < 5; i++) begin
                if (paddr == 8'(`CMS_OFF_CTRL0 + 4 * i)) begin
                    rd_data[7:0] = ctrl_ff[i];
                    rd_hit = 1'b1;
                end
                if (paddr == 8'(`CMS_OFF_VAL0 + 4 * i)) begin
                    rd_data[15:0] = val_ff[i];
                    rd_hit = 1'b1;
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (paddr == 8'(`CMS_OFF_DB0 + 4 * i)) begin
                    rd_data[6:0] = db_ff[i];
                    rd_hit = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= rd_take;
            if (rd_take) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr_ff <= ~rd_hit;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Mode control; plain channels keep configuration bits at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                ctrl_ff[i] <= `CMS_CTRL_RST;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (ctrl_wr[i]) begin
                    ctrl_ff[i] <= pwdata[7:0] & ((i < 3) ? 8'hff : 8'h3f);
                end
            end
        end
    end

    // Compare value and duty high byte; a capture overrides a same-cycle write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                val_ff[i] <= `CMS_VAL_RST;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (cap_evt[i]) begin
                    val_ff[i] <= base_count;
                end else if (val_wr[i]) begin
                    val_ff[i] <= pwdata[15:0];
                end
            end
        end
    end

    // Timer selection registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsel_a_ff <= `CMS_TSEL_A_RST;
            tsel_b_ff <= `CMS_TSEL_B_RST;
        end else begin
            if (tsel_a_wr) begin
                tsel_a_ff <= pwdata[7:0];
            end
            if (tsel_b_wr) begin
                tsel_b_ff <= pwdata[1:0];
            end
        end
    end

    // Dead-band counts for the enhanced channels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                db_ff[i] <= `CMS_DB_RST;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (db_wr[i]) begin
                    db_ff[i] <= pwdata[6:0];
                end
            end
        end
    end

    // Pin relocation register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reloc_ff <= `CMS_RELOC_RST;
        end else if (reloc_wr) begin
            reloc_ff <= pwdata[7:0];
        end
    end

    // Sticky channel flags, write one to clear; a new event wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 5'h00;
        end else begin
            flag_ff <= (flag_ff & ~(flag_wr ? pwdata[4:0] : 5'h00)) | cap_evt | cmp_evt;
        end
    end

    // ----------------------------------------------------------------
    // Inputs and events
    // ----------------------------------------------------------------
    // Two-stage synchroniser for the capture pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_s1_ff <= 5'h00;
            cap_s2_ff <= 5'h00;
        end else begin
            cap_s1_ff <= capture_pin;
            cap_s2_ff <= cap_s1_ff;
        end
    end

    // Conversion start from any channel's special event while adc_enabled is set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_start_ff <= 1'b0;
        end else begin
            adc_start_ff <= |adc_go;
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    assign tsel[0] = tsel_a_ff[1:0];
    assign tsel[1] = tsel_a_ff[3:2];
    assign tsel[2] = tsel_a_ff[5:4];
    assign tsel[3] = tsel_a_ff[7:6];
    assign tsel[4] = tsel_b_ff;

    // Three enhanced channels followed by two plain ones.
    for (genvar g = 0; g < 5; g++) begin : g_ch
        cms_channel #(
            .ENH((g < 3) ? 1'b1 : 1'b0)
        ) u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .mode(ctrl_ff[g][`CMS_MODE_MSB:`CMS_MODE_LSB]),
            .ocfg(ctrl_ff[g][`CMS_CFG_MSB:`CMS_CFG_LSB]),
            .duty({val_ff[g][7:0], ctrl_ff[g][`CMS_DLOW_MSB:`CMS_DLOW_LSB]}),
            .cmp_val(val_ff[g]),
            .tsel(tsel[g]),
            .db_count((g < 3) ? db_ff[(g < 3) ? g : 0] : 7'h00),
            .tmr_count(tmr_count),
            .tmr_period(tmr_period),
            .base_count(base_count),
            .cap_in(cap_s2_ff[g]),
            .adc_en(adc_enabled),
            .cap_evt_ff(cap_evt[g]),
            .cmp_evt_ff(cmp_evt[g]),
            .tmr_rst_ff(tmr_rst[g]),
            .adc_go_ff(adc_go[g]),
            .lvl_ff(lvl[4 * g +: 4]),
            .oe_n_ff(oe_n[4 * g +: 4])
        );
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign out_level = lvl;
    assign out_oe_n = oe_n;
    assign timer_reset = tmr_rst;
    assign adc_start = adc_start_ff;
    assign pin_relocation = reloc_ff;

endmodule

`default_nettype wire

//--- bench/cms_checker.sv
`default_nettype none

module cms_checker (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and events.
    input wire logic [19:0] out_oe_n,
    input wire logic [4:0] timer_reset,
    input wire logic adc_start,
    input wire logic adc_enabled,
    input wire logic [7:0] pin_relocation
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_a: assert property (psel && !penable |-> ##2 pready) else $error("late bus answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_err_a: assert property (pready && paddr > 8'h44 |-> pslverr) else $error("no error");
    tsel_b_a: assert property (pready && !pwrite && paddr == 8'h2c |-> prdata[31:2] == 30'h0)
        else $error("select b upper bits set");
    plain_ctrl_a: assert property (pready && !pwrite && paddr inside {8'h0c, 8'h10} |-> prdata[7:6] == 2'h0)
        else $error("plain channel config bits set");
    plain_pins_a: assert property (out_oe_n[19:17] == 3'h7 && out_oe_n[15:13] == 3'h7)
        else $error("plain channel drives b to d");
    reloc_write_a: assert property ($changed(pin_relocation) |-> $past(pready && pwrite && paddr == 8'h40))
        else $error("relocation changed alone");
    adc_follow_a: assert property (|timer_reset && adc_enabled |=> adc_start)
        else $error("conversion not started");
    adc_cause_a: assert property (adc_start |-> $past(|timer_reset))
        else $error("conversion without match");
endmodule

bind cms_top cms_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .out_oe_n, .timer_reset, .adc_start, .adc_enabled, .pin_relocation);

`default_nettype wire

//--- bench/cms_timer_model.sv
`default_nettype none

module cms_timer_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Time bases.
    output logic [29:0] tmr_count,
    output logic [2:0] tmr_period,
    output logic [15:0] base_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt_ff;
    // One counter feeds timers of 32, 16 and 8 counts and an 8-bit wrapping base.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 5'h00;
            base_count <= 16'h0000;
        end else begin
            cnt_ff <= cnt_ff + 5'h01;
            base_count <= {8'h00, base_count[7:0] + 8'h01};
        end
    end
    // Period start pulses fire when each count is zero.
    assign tmr_count = {7'h00, cnt_ff[2:0], 6'h00, cnt_ff[3:0], 5'h00, cnt_ff};
    assign tmr_period = {cnt_ff[2:0] == 3'h0, cnt_ff[3:0] == 4'h0, cnt_ff == 5'h00};
endmodule

`default_nettype wire

//--- bench/cms_top_test.sv
`default_nettype none

module cms_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, adc_start;
    logic adc_enabled = 1'b1, tr_seen = 1'b0;
    logic [7:0] paddr = 8'h00, pin_relocation;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [29:0] tmr_count;
    logic [2:0] tmr_period;
    logic [15:0] base_count;
    logic [4:0] capture_pin = 5'h00, timer_reset;
    logic [19:0] out_level, out_oe_n;
    int errors = 0, samples_checked = 0, hi;
    cms_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tmr_count, .tmr_period, .base_count, .adc_enabled, .capture_pin, .out_level, .out_oe_n,
        .timer_reset, .adc_start, .pin_relocation);
    cms_timer_model tm_u (.pclk, .presetn, .tmr_count, .tmr_period, .base_count);
    // Clock and a sticky record of timer reset pulses.
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (timer_reset[0] === 1'b1) tr_seen <= 1'b1;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // One bus transfer; read data is taken at the edge where ready is seen.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs();
        apb(0, 8'h28, 0); chk("tsel_a reset", 0, rd);
        apb(1, 8'h28, 32'he4); apb(0, 8'h28, 0); chk("tsel_a", 32'he4, rd);
        apb(1, 8'h2c, 32'hff); apb(0, 8'h2c, 0); chk("tsel_b", 32'h3, rd);
        apb(1, 8'h10, 32'hcc); apb(0, 8'h10, 0); chk("plain ctrl", 32'h0c, rd);
        apb(1, 8'h40, 32'h5a);
        @(posedge pclk);
        chk("reloc", 32'h5a, pin_relocation);
        apb(0, 8'h80, 0); chk("unmapped", 0, rd);
    endtask
    task automatic t_compare();
        apb(1, 8'h14, 32'h40);
        for (int m = 8; m < 12; m++) begin
            tr_seen = 1'b0;
            apb(1, 8'h00, 0); apb(1, 8'h3c, 1);
            apb(1, 8'h00, 32'hc0 | m);
            repeat (3) @(posedge pclk);
            if (m < 11) chk("init oe", m == 10 ? 4'hf : 4'he, out_oe_n[3:0]);
            if (m < 10) chk("init lvl", m - 8, out_level[0]);
            while (base_count !== 16'h0040) @(posedge pclk);
            repeat (4) @(posedge pclk);
            if (m < 10) chk("match lvl", 9 - m, out_level[0]);
            apb(0, 8'h3c, 0); chk("flag", 1, rd[0]);
            chk("timer reset", m == 11, tr_seen);
        end
        apb(1, 8'h00, 0); repeat (2) @(posedge pclk);
        chk("off oe", 4'hf, out_oe_n[3:0]);
    endtask
    // Rising, falling and every-fourth capture on channel one; the value is the base seen four edges on.
    task automatic t_capture();
        logic [15:0] cap_exp;
        apb(1, 8'h00, 32'h05);
        apb(1, 8'h3c, 1);
        capture_pin[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        cap_exp = base_count;
        repeat (2) @(posedge pclk);
        apb(0, 8'h14, 0);
        chk("capture value", cap_exp, rd);
        apb(1, 8'h00, 32'h04);
        apb(1, 8'h3c, 1);
        capture_pin[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(0, 8'h3c, 0);
        chk("fall capture", 1, rd[0]);
        apb(1, 8'h00, 32'h06);
        apb(1, 8'h3c, 1);
        for (int i = 1; i <= 4; i++) begin
            capture_pin[0] <= 1'b1;
            repeat (4) @(posedge pclk);
            capture_pin[0] <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(0, 8'h3c, 0);
            chk("capture four", i == 4, rd[0]);
        end
        apb(1, 8'h00, 0);
    endtask
    // Duty of 6 on the 16-count timer; the high polarity bit (mode bit 1) inverts output a.
    task automatic t_pwm();
        apb(1, 8'h28, 1); apb(1, 8'h14, 1);
        for (int m = 12; m < 15; m += 2) begin
            apb(1, 8'h00, 32'h20 | m);
            repeat (40) @(posedge pclk);
            hi = 0;
            repeat (64) begin @(posedge pclk); hi += out_level[0]; end
            chk("pwm high", m == 12 ? 24 : 40, hi);
            chk("pwm oe", 4'he, out_oe_n[3:0]);
        end
        apb(1, 8'h00, 32'h6c);
        repeat (3) @(posedge pclk);
        chk("fwd oe a", 32'h1, {out_oe_n[3:0], out_level[0]});
        apb(1, 8'h00, 32'hec);
        repeat (3) @(posedge pclk);
        chk("rev c a", 32'h2, {out_level[2], out_level[0]});
        apb(1, 8'h00, 32'hac);
        repeat (3) @(posedge pclk);
        chk("half oe", 32'hc, out_oe_n[3:0]);
        apb(1, 8'h28, 32'h3);
        repeat (3) @(posedge pclk);
        chk("rsvd oe", 32'hf, out_oe_n[3:0]);
    endtask
    task automatic results();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence after ten cycles of reset.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_compare();
        t_capture();
        t_pwm();
        results();
    end
    // Watchdog for a hung wait on base_count.
    initial begin
        #400000;
        errors++;
        results();
    end
endmodule

`default_nettype wire
